// ---- src/adc_conversion_control.sv ----
`timescale 1ns/1ps
// Notes on behaviour
// RULE1 - Sleep conversion continues only on RC clock
// RULE2 - RC clock start waits one instruction
// RULE3 - Completion wakes device when interrupt enabled
// RULE4 - Sleep done, interrupt off: power down
// RULE5 - Sleep on system clock aborts, powers down
// RULE6 - Special trigger starts conversion, clears timer
// RULE7 - Software ensures timing for triggered starts
// RULE8 - Software configures clock, channel, enable first
// RULE9 - Software waits acquisition time before start
// RULE10 - Software polls start bit or interrupt
// RULE11 - Software clears complete flag after read
// RULE12 - Software may keep global interrupts off
// RULE13 - Top two control bits read zero
// RULE14 - Channel codes select pins, temperature, reference
// RULE15 - Start bit starts, reads busy, self-clears
// RULE16 - Enable bit powers converter
// RULE17 - Completion clears start, sets flag, stores
// RULE18 - Abort stores partial, fills from last bit
// RULE19 - Conversion takes ten conversion periods
// RULE20 - Clock code selects divider or RC
// RULE21 - Unassigned channel codes select nothing
// RULE22 - Reset clears control register
module adc_conversion_control (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        reset_n,
  // AXI4-Lite write address
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  // AXI4-Lite write data
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  // AXI4-Lite write response
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // AXI4-Lite read
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // Device and trigger events
  input  wire logic        sleepReq,
  input  wire logic        specialTrig,
  input  wire logic        rcTick,
  // Analog front end
  input  wire logic        compIn,
  output logic [7:0]       dacCode,
  output logic             sampleHold,
  output logic [13:0]      channelOn,
  output logic             converterOn,
  // System outputs
  output logic             completeFlag,
  output logic             wakeReq,
  output logic             timerClear
);
  adc_pkg::adc_primary_t primaryQ;      // Primary control
  logic [2:0]            clkSelQ;       // Conversion clock code
  logic [7:0]            resultQ;       // Conversion result
  logic                  flagQ;         // Conversion complete
  logic                  intEnQ;        // Complete interrupt enable
  logic                  sleepOffQ;     // Powered down after sleep
  adc_pkg::adc_state_t   stateQ;        // Sequencer state
  logic [2:0]            delayCntQ;     // Start delay counter
  logic [3:0]            tadCntQ;       // Periods elapsed
  logic [7:0]            sarQ;          // Approximation register
  logic [3:0]            bitsDoneQ;     // Bits resolved so far
  logic                  awHeldQ;       // Write address captured
  logic [7:0]            awAddrQ;       // Captured write address
  logic                  wHeldQ;        // Write data captured
  logic [31:0]           wDataQ;        // Captured write data
  logic                  wLaneQ;        // Low byte lane enabled
  logic                  tadTick;       // Conversion period pulse
  logic                  rcSel;         // RC clock chosen
  logic                  wrEn;          // Register write this cycle
  logic                  priWr;         // Primary register write
  logic                  busy;          // Sequencer not idle
  logic                  done;          // Conversion finishes
  logic                  sleepAbort;    // Sleep aborts conversion
  logic                  swAbort;       // Software clears start
  logic                  disAbort;      // Enable cleared mid-run
  logic [7:0]            partial;       // Filled partial result
  logic                  chanValid;     // Channel code assigned

  // Conversion period generator
  adc_tad_gen u_tad (
    .mclk    (mclk),
    .reset_n (reset_n),
    .clear   (stateQ != adc_pkg::ST_RUN),
    .clkSel  (clkSelQ),
    .rcTick  (rcTick),
    .tadTick (tadTick)
  );

  // Event decode
  always_comb begin
    rcSel      = (clkSelQ[1:0] == adc_pkg::CS_RC_LOW); // RULE20
    wrEn       = awHeldQ && wHeldQ && !bvalid;
    priWr      = wrEn && wLaneQ && (awAddrQ == adc_pkg::OFF_PRIMARY);
    busy       = (stateQ != adc_pkg::ST_IDLE);
    done       = (stateQ == adc_pkg::ST_RUN) && tadTick &&
                 (tadCntQ == 4'(adc_pkg::TAD_PER_CONV - 1)); // RULE19
    sleepAbort = busy && sleepReq && !rcSel; // RULE1 RULE5
    swAbort    = busy && priWr && !wDataQ[adc_pkg::PRI_GO_BIT];
    disAbort   = busy && priWr && !wDataQ[adc_pkg::PRI_EN_BIT];
  end

  // Partial result, unresolved bits copy the last one
  always_comb begin
    partial = sarQ;
    for (int i = 0; i < adc_pkg::BITS; i++) begin
      if (i < adc_pkg::BITS - int'(bitsDoneQ)) begin
        partial[i] = (bitsDoneQ == 4'h0) ? 1'b0 :
                     sarQ[adc_pkg::BITS - int'(bitsDoneQ)]; // RULE18
      end
    end
  end

  // Write address and data capture, either order
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      awHeldQ <= 1'b0;
      awAddrQ <= 8'h00;
      wHeldQ  <= 1'b0;
      wDataQ  <= 32'h0000_0000;
      wLaneQ  <= 1'b0;
    end else begin
      if (awvalid && awready) begin
        awHeldQ <= 1'b1;
        awAddrQ <= awaddr;
      end else if (wrEn) begin
        awHeldQ <= 1'b0;
      end
      if (wvalid && wready) begin
        wHeldQ <= 1'b1;
        wDataQ <= wdata;
        wLaneQ <= wstrb[0];
      end else if (wrEn) begin
        wHeldQ <= 1'b0;
      end
    end
  end

  // Write response, error for unmapped offsets
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      bvalid <= 1'b0;
      bresp  <= adc_pkg::RESP_OKAY;
    end else if (wrEn) begin
      bvalid <= 1'b1;
      bresp  <= (awAddrQ > adc_pkg::OFF_STATUS || awAddrQ[1:0] != 2'h0)
                ? adc_pkg::RESP_SLVERR : adc_pkg::RESP_OKAY;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // Read data and response
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= adc_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rresp  <= adc_pkg::RESP_OKAY;
      case (araddr)
        adc_pkg::OFF_PRIMARY:   rdata <= {26'h0, primaryQ}; // RULE13
        adc_pkg::OFF_SECONDARY: rdata <= {25'h0, clkSelQ, 4'h0};
        adc_pkg::OFF_RESULT:    rdata <= {24'h0, resultQ};
        adc_pkg::OFF_STATUS:
          rdata <= {28'h0, busy, converterOn, intEnQ, flagQ};
        default: begin
          rdata <= 32'h0000_0000;
          rresp <= adc_pkg::RESP_SLVERR;
        end
      endcase
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  // Handshake readies
  always_comb begin
    awready = !awHeldQ;
    wready  = !wHeldQ;
    arready = !rvalid;
  end

  // Primary control register
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      primaryQ <= '0; // RULE22
    end else begin
      if (priWr) begin
        primaryQ.channel_select_field <= wDataQ[adc_pkg::PRI_CHS_LSB +: 4];
        primaryQ.en  <= wDataQ[adc_pkg::PRI_EN_BIT]; // RULE16
        // Start only when enabled; write of zero aborts
        primaryQ.go  <= wDataQ[adc_pkg::PRI_GO_BIT] &&
                        wDataQ[adc_pkg::PRI_EN_BIT]; // RULE15
      end else if (done || sleepAbort) begin
        primaryQ.go  <= 1'b0; // RULE15 RULE17 RULE5
      end
      // Hardware trigger sets start, wins over clears
      if (specialTrig && primaryQ.en && !busy) begin
        primaryQ.go  <= 1'b1; // RULE6
      end
    end
  end

  // Secondary register and interrupt enable
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      clkSelQ <= adc_pkg::CS_RST;
      intEnQ  <= 1'b0;
    end else if (wrEn && wLaneQ) begin
      if (awAddrQ == adc_pkg::OFF_SECONDARY) begin
        clkSelQ <= wDataQ[adc_pkg::SEC_CS_LSB +: 3]; // RULE20
      end
      if (awAddrQ == adc_pkg::OFF_STATUS) begin
        intEnQ <= wDataQ[adc_pkg::STA_IE_BIT];
      end
    end
  end

  // Complete flag, write zero clears, set wins
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      flagQ <= 1'b0;
    end else if (done) begin
      flagQ <= 1'b1; // RULE17
    end else if (wrEn && wLaneQ && awAddrQ == adc_pkg::OFF_STATUS &&
                 !wDataQ[adc_pkg::STA_FLAG_BIT]) begin
      flagQ <= 1'b0;
    end
  end

  // Result register, hardware update wins over bus
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      resultQ <= adc_pkg::RESULT_RST;
    end else if (done) begin
      resultQ <= sarQ; // RULE17
    end else if (swAbort && stateQ == adc_pkg::ST_RUN) begin
      resultQ <= partial; // RULE18
    end else if (wrEn && wLaneQ && awAddrQ == adc_pkg::OFF_RESULT) begin
      resultQ <= wDataQ[7:0];
    end
  end

  // Conversion sequencer
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      stateQ    <= adc_pkg::ST_IDLE;
      delayCntQ <= 3'h0;
      tadCntQ   <= 4'h0;
      sarQ      <= 8'h00;
      bitsDoneQ <= 4'h0;
    end else if (swAbort || disAbort || sleepAbort) begin
      stateQ <= adc_pkg::ST_IDLE; // RULE5
    end else begin
      case (stateQ)
        adc_pkg::ST_IDLE: begin
          delayCntQ <= 3'h0;
          tadCntQ   <= 4'h0;
          bitsDoneQ <= 4'h0;
          sarQ      <= 8'h80;
          if (primaryQ.go) begin
            // RC start leaves room for the sleep instruction
            stateQ <= rcSel ? adc_pkg::ST_DELAY
                            : adc_pkg::ST_RUN; // RULE2
          end
        end
        adc_pkg::ST_DELAY: begin
          delayCntQ <= delayCntQ + 3'h1;
          if (delayCntQ == 3'(adc_pkg::INSTR_CLKS - 1)) begin
            stateQ <= adc_pkg::ST_RUN; // RULE2
          end
        end
        adc_pkg::ST_RUN: begin
          if (tadTick) begin
            tadCntQ <= tadCntQ + 4'h1; // RULE19
            // Periods one to eight each resolve one bit
            if (tadCntQ >= 4'h1 && tadCntQ <= 4'(adc_pkg::BITS)) begin
              for (int i = 0; i < adc_pkg::BITS; i++) begin
                if (i == adc_pkg::BITS - int'(tadCntQ)) begin
                  sarQ[i] <= compIn;
                  if (i > 0) begin
                    sarQ[i-1] <= 1'b1;
                  end
                end
              end
              bitsDoneQ <= tadCntQ;
            end
            if (done) begin
              stateQ <= adc_pkg::ST_IDLE;
            end
          end
        end
        default: stateQ <= adc_pkg::ST_IDLE;
      endcase
    end
  end

  // Sleep power down and wake pulse
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      sleepOffQ <= 1'b0;
      wakeReq   <= 1'b0;
    end else begin
      wakeReq <= done && sleepReq && intEnQ; // RULE3
      if (done && sleepReq && !intEnQ) begin
        sleepOffQ <= 1'b1; // RULE4
      end else if (!sleepReq) begin
        sleepOffQ <= 1'b0;
      end
    end
  end

  // Timer clear pulse on special trigger
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      timerClear <= 1'b0;
    end else begin
      timerClear <= specialTrig && primaryQ.en && !busy; // RULE6
    end
  end

  // Analog outputs and channel routing
  always_comb begin
    converterOn = primaryQ.en && !sleepOffQ &&
                  !(sleepReq && !rcSel); // RULE16 RULE4 RULE5
    chanValid   = (primaryQ.channel_select_field <= adc_pkg::CHS_LAST_PIN) ||
                  (primaryQ.channel_select_field == adc_pkg::CHS_TEMP) ||
                  (primaryQ.channel_select_field == adc_pkg::CHS_FVR); // RULE21
    channelOn   = 14'h0000;
    if (converterOn && chanValid) begin
      // Bits 0-11 pins, 12 temperature, 13 reference
      if (primaryQ.channel_select_field <= adc_pkg::CHS_LAST_PIN) begin
        channelOn[primaryQ.channel_select_field] = 1'b1; // RULE14
      end else begin
        channelOn[{3'h6, primaryQ.channel_select_field[0]}] = 1'b1; // RULE14
      end
    end
    sampleHold   = (stateQ == adc_pkg::ST_RUN);
    dacCode      = sarQ;
    completeFlag = flagQ;
  end
endmodule

// ---- src/adc_pkg.sv ----
package adc_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_PRIMARY   = 8'h00;
  localparam logic [7:0] OFF_SECONDARY = 8'h04;
  localparam logic [7:0] OFF_RESULT    = 8'h08;
  localparam logic [7:0] OFF_STATUS    = 8'h0C;
  // Primary control fields
  localparam int PRI_EN_BIT  = 0;
  localparam int PRI_GO_BIT  = 1;
  localparam int PRI_CHS_LSB = 2;
  // Secondary control field
  localparam int SEC_CS_LSB  = 4;
  // Status register fields
  localparam int STA_FLAG_BIT  = 0;
  localparam int STA_IE_BIT    = 1;
  localparam int STA_PWR_BIT   = 2;
  localparam int STA_BUSY_BIT  = 3;
  // Channel codes
  localparam logic [3:0] CHS_LAST_PIN = 4'h000B;
  localparam logic [3:0] CHS_TEMP     = 4'h000E;
  localparam logic [3:0] CHS_FVR      = 4'h000F;
  // Conversion clock codes, low two bits set selects RC
  localparam logic [1:0] CS_RC_LOW    = 2'h3;
  // Reset values
  localparam logic [7:0] RESULT_RST   = 8'h0000;
  localparam logic [2:0] CS_RST       = 3'h0;
  // Conversion timing
  localparam int BITS           = 8;
  localparam int TAD_PER_CONV   = 10;
  localparam int CLK_PERIOD_NS  = 8;
  localparam int INSTR_CYCLE_NS = 32;
  localparam int INSTR_CLKS =
    (INSTR_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Primary control register contents
  typedef struct packed {
    logic [3:0] channel_select_field;
    logic       go;
    logic       en;
  } adc_primary_t;
  // Sequencer states
  typedef enum logic [1:0] {ST_IDLE, ST_DELAY, ST_RUN} adc_state_t;
endpackage

// ---- src/adc_tad_gen.sv ----
`timescale 1ns/1ps
module adc_tad_gen (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       reset_n,
  // Control
  input  wire logic       clear,
  input  wire logic [2:0] clkSel,
  input  wire logic       rcTick,
  // Conversion period tick
  output logic            tadTick
);
  logic [5:0] divCntQ;  // System clock divider
  logic [5:0] divLast;  // Terminal count for the code
  logic       rcSel;    // Dedicated oscillator chosen

  // Terminal count per clock code
  always_comb begin
    rcSel = (clkSel[1:0] == adc_pkg::CS_RC_LOW);
    case (clkSel)
      3'h0:    divLast = 6'h01;
      3'h4:    divLast = 6'h03;
      3'h1:    divLast = 6'h07;
      3'h5:    divLast = 6'h0F;
      3'h2:    divLast = 6'h1F;
      3'h6:    divLast = 6'h3F;
      default: divLast = 6'h3F;
    endcase
  end

  // Divider counter, restarted while clear is high
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      divCntQ <= 6'h00;
    end else if (clear || divCntQ == divLast) begin
      divCntQ <= 6'h00;
    end else begin
      divCntQ <= divCntQ + 6'h01;
    end
  end

  // One pulse per conversion period
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      tadTick <= 1'b0;
    end else if (clear) begin
      tadTick <= 1'b0;
    end else if (rcSel) begin
      tadTick <= rcTick;
    end else begin
      tadTick <= (divCntQ == divLast);
    end
  end
endmodule

// ---- test/adc_analog_model.sv ----
`timescale 1ns/1ps
// Analog side: comparator on a held level and a free running RC tick
module adc_analog_model #(
  parameter int RC_DIV = 5  // Clock cycles per RC conversion period
) (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       reset_n,
  // Analog level and converter side
  input  wire logic [7:0] level,
  input  wire logic [7:0] dacCode,
  input  wire logic       sampleHold,
  output logic            compIn,
  output logic            rcTick
);
  int   rcCnt;     // RC oscillator phase
  logic toggle_q;  // Noise while nothing is held
  // RC oscillator runs free, sleep or not
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rcCnt <= 0;
      rcTick <= 1'b0;
      toggle_q <= 1'b0;
    end else begin
      rcCnt <= (rcCnt == RC_DIV - 1) ? 0 : rcCnt + 1;
      rcTick <= (rcCnt == RC_DIV - 1);
      toggle_q <= ~toggle_q;
    end
  end
  // Comparator is only meaningful while the input is held
  assign compIn = sampleHold ? (level >= dacCode) : toggle_q;
endmodule

// ---- test/adc_conversion_control_props.sv ----
`timescale 1ns/1ps
// Watches the bus and converter outputs of the top module
module adc_conversion_control_props (
  // Clock and reset
  input wire logic        mclk,
  input wire logic        reset_n,
  // Register read channel
  input wire logic [7:0]  araddr,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0]  rresp,
  input wire logic        rvalid,
  // Converter and events
  input wire logic        sleepReq,
  input wire logic        specialTrig,
  input wire logic        sampleHold,
  input wire logic [13:0] channelOn,
  input wire logic        converterOn,
  input wire logic        completeFlag,
  input wire logic        wakeReq,
  input wire logic        timerClear
);
  logic [7:0] rdAddr_q;  // Address of the read under way
  // Capture the address when a read is taken
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rdAddr_q <= 8'h00;
    end else if (arvalid && arready) begin
      rdAddr_q <= araddr;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  a_top_bits_zero: assert property (
    rvalid && rdAddr_q == adc_pkg::OFF_PRIMARY |-> rdata[31:6] == 26'h000_0000)
    else $error("primary register upper bits not zero");
  a_error_reads_zero: assert property (
    rvalid && rresp == adc_pkg::RESP_SLVERR |-> rdata == 32'h0000_0000)
    else $error("refused read returned data");
  a_read_answer: assert property (
    arvalid && arready |=> rvalid)
    else $error("read answer late");
  a_flag_on_done: assert property (
    $rose(completeFlag) |-> $past(sampleHold) && !sampleHold)
    else $error("flag set without finished run");
  a_timer_pulse: assert property (
    timerClear |-> ($past(specialTrig) || $past(specialTrig, 2)) ##1 !timerClear)
    else $error("timer clear without trigger");
  a_wake_cause: assert property (
    wakeReq |-> completeFlag && sleepReq ##1 !wakeReq)
    else $error("wake without completion in sleep");
  a_chan_onehot: assert property (
    channelOn != 14'h0000 |-> converterOn && $onehot(channelOn))
    else $error("channel routing not one-hot");
  a_off_idle: assert property (
    !converterOn |=> !sampleHold)
    else $error("sampling while converter off");
endmodule

bind adc_conversion_control adc_conversion_control_props u_props (
  .mclk, .reset_n, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
  .sleepReq, .specialTrig, .sampleHold, .channelOn, .converterOn,
  .completeFlag, .wakeReq, .timerClear);

// ---- test/adc_conversion_control_tb.sv ----
`timescale 1ns/1ps
// Self-checking bench for the conversion control block
module adc_conversion_control_tb;
  localparam int RCD = 5;  // RC period in clock cycles
  // Clock, reset and bus master
  logic        mclk;
  logic        reset_n = 1'b0;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0]  wstrb = 4'h0;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b1;  // Responses always accepted
  logic        arvalid = 1'b0;
  logic        rready = 1'b1;
  logic        sleepReq = 1'b0;
  logic        specialTrig = 1'b0;
  logic [7:0]  level = 8'h00;  // Analog input level
  // Design outputs
  logic        awready, wready, bvalid, arready, rvalid, compIn, rcTick;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [7:0]  dacCode;
  logic        sampleHold, converterOn, completeFlag, wakeReq, timerClear;
  logic [13:0] channelOn;
  int          n_mismatch = 0;
  int          n_checks = 0;
  logic [1:0]  lastB = 2'h0;  // Response of the last write
  int          cyc = 0;  // Clock cycle count
  int          tad[8] = '{2, 8, 32, RCD, 4, 16, 64, RCD};  // Period per code
  adc_conversion_control DUT (.mclk, .reset_n, .awaddr, .awvalid, .awready,
    .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
    .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .sleepReq,
    .specialTrig, .rcTick, .compIn, .dacCode, .sampleHold, .channelOn,
    .converterOn, .completeFlag, .wakeReq, .timerClear);
  adc_analog_model #(.RC_DIV(RCD)) u_model (.mclk, .reset_n, .level,
    .dacCode, .sampleHold, .compIn, .rcTick);
  // Clock
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  always @(posedge mclk) cyc <= cyc + 1;
  // Verdict and end of run
  task automatic print_verdict();
    if (n_mismatch == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Bus write, address and data offered together
  task automatic w(input logic [7:0] a, input logic [31:0] d);
    logic ar, wr, bv;
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'h1;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    forever begin
      // Sample settled answers away from the rising edge
      @(negedge mclk);
      ar = awready;
      wr = wready;
      bv = bvalid;
      lastB = bresp;
      @(posedge mclk);
      if (awvalid && ar) awvalid <= 1'b0;
      if (wvalid && wr) wvalid <= 1'b0;
      if (bv === 1'b1) break;
    end
  endtask
  // Bus read
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    logic ar, rv;
    araddr <= a;
    arvalid <= 1'b1;
    forever begin
      // Sample settled answers away from the rising edge
      @(negedge mclk);
      ar = arready;
      rv = rvalid;
      d = rdata;
      r = rresp;
      @(posedge mclk);
      if (arvalid && ar) arvalid <= 1'b0;
      if (rv === 1'b1) break;
    end
  endtask
  // Read and compare
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chk(d, e);
  endtask
  // Wait until the hold output reaches a level
  task automatic waitHold(input logic v);
    @(negedge mclk);
    while (sampleHold !== v) @(negedge mclk);
    @(posedge mclk);
  endtask
  // Reset values, unmapped place, channel routing
  task automatic s_regs();
    logic [31:0] d;
    logic [1:0]  r;
    logic [13:0] e;
    rc(adc_pkg::OFF_PRIMARY, 32'h0000_0000);
    rc(adc_pkg::OFF_STATUS, 32'h0000_0000);
    rd(8'h10, d, r);
    chk(d, 32'h0000_0000);
    chk(32'(r), 32'(adc_pkg::RESP_SLVERR));
    w(8'h10, 32'h0000_0001);
    chk(32'(lastB), 32'(adc_pkg::RESP_SLVERR));
    w(adc_pkg::OFF_PRIMARY, 32'h0000_00FC);
    rc(adc_pkg::OFF_PRIMARY, 32'h0000_003C);
    chk(32'(channelOn), 32'h0000_0000);
    for (int c = 0; c < 16; c++) begin
      w(adc_pkg::OFF_PRIMARY, 32'(c) << 2 | 32'h0000_0001);
      e = c < 12 ? 14'(1 << c) : c == 14 ? 14'h1000 :
          c == 15 ? 14'h2000 : 14'h0;
      chk(32'(channelOn), 32'(e));
      chk(32'(converterOn), 32'h0000_0001);
    end
  endtask
  // Every clock code: timing, result, start delay
  task automatic s_conv();
    int dly[8];
    int t0;
    logic [7:0] lv;
    for (int k = 0; k < 8; k++) begin
      lv = 8'h5A + 8'(k * 29);
      level <= lv;
      w(adc_pkg::OFF_SECONDARY, 32'(k) << 4);
      w(adc_pkg::OFF_PRIMARY, 32'h0000_0001);
      repeat (8) @(posedge mclk);
      w(adc_pkg::OFF_PRIMARY, 32'h0000_0003);
      t0 = cyc;
      waitHold(1'b1);
      dly[k] = cyc - t0;
      t0 = cyc;
      rc(adc_pkg::OFF_PRIMARY, 32'h0000_0003);
      waitHold(1'b0);
      chk(32'(cyc - t0 >= 9 * tad[k] && cyc - t0 <= 11 * tad[k]), 1);
      rc(adc_pkg::OFF_RESULT, 32'(lv));
      rc(adc_pkg::OFF_PRIMARY, 32'h0000_0001);
      rc(adc_pkg::OFF_STATUS, 32'h0000_0005);
      w(adc_pkg::OFF_STATUS, 32'h0000_0000);
    end
    chk(32'(dly[3] - dly[0]), 32'(adc_pkg::INSTR_CLKS));
    chk(32'(dly[7] - dly[4]), 32'(adc_pkg::INSTR_CLKS));
  endtask
  // Software abort mid-run, then sleep on the system clock
  task automatic s_abort();
    level <= 8'h80;
    w(adc_pkg::OFF_SECONDARY, 32'h0000_0060);
    w(adc_pkg::OFF_PRIMARY, 32'h0000_0003);
    waitHold(1'b1);
    repeat (320) @(posedge mclk);
    w(adc_pkg::OFF_PRIMARY, 32'h0000_0001);
    rc(adc_pkg::OFF_RESULT, 32'h0000_0080);
    rc(adc_pkg::OFF_STATUS, 32'h0000_0004);
    w(adc_pkg::OFF_PRIMARY, 32'h0000_0003);
    waitHold(1'b1);
    sleepReq <= 1'b1;
    repeat (2) @(posedge mclk);
    chk(32'(converterOn), 32'h0000_0000);
    rc(adc_pkg::OFF_PRIMARY, 32'h0000_0001);
    rc(adc_pkg::OFF_STATUS, 32'h0000_0000);
    sleepReq <= 1'b0;
  endtask
  // RC clock conversions while asleep, wake and power down
  task automatic s_sleep();
    level <= 8'h3C;
    w(adc_pkg::OFF_SECONDARY, 32'h0000_0070);
    w(adc_pkg::OFF_STATUS, 32'h0000_0002);
    w(adc_pkg::OFF_PRIMARY, 32'h0000_0003);
    sleepReq <= 1'b1;
    while (wakeReq !== 1'b1) @(negedge mclk);
    chk(32'(completeFlag), 32'h0000_0001);
    @(posedge mclk);
    sleepReq <= 1'b0;
    rc(adc_pkg::OFF_RESULT, 32'h0000_003C);
    w(adc_pkg::OFF_STATUS, 32'h0000_0000);
    w(adc_pkg::OFF_PRIMARY, 32'h0000_0003);
    sleepReq <= 1'b1;
    waitHold(1'b1);
    waitHold(1'b0);
    @(posedge mclk);
    chk(32'(converterOn), 32'h0000_0000);
    rc(adc_pkg::OFF_PRIMARY, 32'h0000_0001);
    sleepReq <= 1'b0;
    w(adc_pkg::OFF_STATUS, 32'h0000_0000);
  endtask
  // Hardware trigger, then reset in mid-run
  task automatic s_trig();
    logic tc;
    tc = 1'b0;
    level <= 8'hC3;
    w(adc_pkg::OFF_SECONDARY, 32'h0000_0000);
    w(adc_pkg::OFF_PRIMARY, 32'h0000_0001);
    specialTrig <= 1'b1;
    repeat (3) begin
      @(posedge mclk);
      specialTrig <= 1'b0;
      @(negedge mclk);
      tc = tc | timerClear;
    end
    @(posedge mclk);
    chk(32'(tc), 32'h0000_0001);
    waitHold(1'b0);
    rc(adc_pkg::OFF_RESULT, 32'h0000_00C3);
    w(adc_pkg::OFF_PRIMARY, 32'h0000_0003);
    waitHold(1'b1);
    reset_n <= 1'b0;
    repeat (2) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    rc(adc_pkg::OFF_PRIMARY, 32'h0000_0000);
  endtask
  // Main sequence
  initial begin
    repeat (4) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    s_regs();
    s_conv();
    s_abort();
    s_sleep();
    s_trig();
    print_verdict();
  end
  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge mclk);
    n_mismatch++;
    print_verdict();
  end
endmodule
